// file: src/psab_top.sv
// PCI-side sideband: parity/system error pins, arbiter, pin reuse, clock outs, interrupts.
// Assumes mclk is the PCI clock taken from the clock input; APB master on the same clock.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "psab_params.svh"
module psab_top (
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 bridge_direction_strap,
    input  wire logic                 speed_66_enable,
    input  wire logic [3:0]           req_n_in,
    output logic      [3:0]           grant_n_out,
    output logic      [3:0]           grant_n_oe,
    input  wire logic [3:0]           pci_clock_out_in,
    output logic      [3:0]           pci_clock_out_out,
    output logic      [3:0]           pci_clock_out_oe,
    input  wire logic                 parity_err_detect,
    output logic                      parity_err_n_out,
    output logic                      parity_err_n_oe,
    input  wire logic                 system_err_n_in,
    output logic                      system_err_n_out,
    output logic                      system_err_n_oe,
    input  wire psab_pkg::psab_irq_t  irq_in,
    output psab_pkg::psab_irq_t       irq_out,
    output psab_pkg::psab_irq_t       irq_oe,
    input  wire psab_pkg::psab_err_t  err_event,
    input  wire logic                 bus_idle,
    input  wire logic                 bridge_req,
    output logic                      park_drive_oe,
    output logic                      bridge_gnt
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and strap capture
    logic [11:0] sync_out;
    logic [3:0]  req_n_s;
    logic        strap_s;
    logic        speed_s;
    logic [3:0]  irq_n_s;
    logic        serr_line_s;
    logic        fb_clk_s;

    psab_sync #(.W(12), .RST_VAL(`PSAB_SYNC_RST)) u_sync (
        .mclk      (mclk),
        .rstn      (rstn),
        .pin_in    ({pci_clock_out_in[0], system_err_n_in, irq_in, speed_66_enable,
                     bridge_direction_strap, req_n_in}),
        .level_out (sync_out)
    );
    assign req_n_s     = sync_out[3:0];
    assign strap_s     = sync_out[4];
    assign speed_s     = sync_out[5];
    assign irq_n_s     = sync_out[9:6];
    assign serr_line_s = sync_out[10];
    assign fb_clk_s    = sync_out[11];

    logic [2:0] strap_cnt_reg;
    logic [2:0] strap_cnt_next;
    logic       strap_done_reg;
    logic       strap_done_next;
    logic       reverse_reg;
    logic       reverse_next;
    logic       clock_run_n_mode_reg;
    logic       clock_run_n_mode_next;

    // Straps are taken only after the synchroniser has filled
    always_comb begin
        strap_cnt_next   = strap_cnt_reg;
        strap_done_next  = strap_done_reg;
        reverse_next     = reverse_reg;
        clock_run_n_mode_next = clock_run_n_mode_reg;
        if (!strap_done_reg) begin
            strap_cnt_next = strap_cnt_reg + 3'h1;
            if (strap_cnt_reg == `PSAB_STRAP_WAIT) begin
                strap_done_next  = 1'b1;
                reverse_next     = strap_s;
                clock_run_n_mode_next = !req_n_s[2] && !req_n_s[3];
            end
        end else if (req_n_s[2] || req_n_s[3]) begin
            clock_run_n_mode_next = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strap_cnt_reg   <= 3'h0;
            strap_done_reg  <= 1'b0;
            reverse_reg     <= 1'b0;
            clock_run_n_mode_reg <= 1'b0;
        end else begin
            strap_cnt_reg   <= strap_cnt_next;
            strap_done_reg  <= strap_done_next;
            reverse_reg     <= reverse_next;
            clock_run_n_mode_reg <= clock_run_n_mode_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB register file
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [8:0]  errstat_reg;
    logic [8:0]  errstat_next;
    logic [31:0] status_word;
    logic [31:0] prdata_next;
    logic        pready_next;
    logic        pslverr_next;
    logic        wr_take;
    logic        hit_ctrl;
    logic        hit_status;
    logic        hit_err;
    logic [4:0]  gnt_vec;
    logic        ext_mode;

    assign hit_ctrl   = paddr[11:2] == 10'(`PSAB_OFF_CTRL >> 2);
    assign hit_status = paddr[11:2] == 10'(`PSAB_OFF_STATUS >> 2);
    assign hit_err    = paddr[11:2] == 10'(`PSAB_OFF_ERRSTAT >> 2);
    assign wr_take    = psel && penable && pready && pwrite;
    assign ext_mode   = reverse_reg || ctrl_reg[`PSAB_CTRL_EXT_ARB];

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`PSAB_ST_REVERSE]     = reverse_reg;
        status_word[`PSAB_ST_CLOCK_RUN_N_MODE] = clock_run_n_mode_reg;
        status_word[`PSAB_ST_SPEED66]     = speed_s;
        status_word[`PSAB_ST_PARK]        = park_drive_oe;
        status_word[`PSAB_ST_GPI_LSB +: 3] = ext_mode ? req_n_s[3:1] : 3'h0;
        status_word[`PSAB_ST_IRQ_LSB +: 4] = ~irq_n_s;
        status_word[`PSAB_ST_GNT_LSB +: 5] = gnt_vec;
        status_word[`PSAB_ST_FB_CLK]      = fb_clk_s;
        status_word[`PSAB_ST_SERR_LINE]   = !serr_line_s;
    end

    // One wait state: data and answer are set up in the first access cycle
    always_comb begin
        ctrl_next    = ctrl_reg;
        errstat_next = errstat_reg;
        prdata_next  = prdata;
        pready_next  = psel && penable && !pready;
        pslverr_next = psel && penable && !pready && !(hit_ctrl || hit_status || hit_err);
        if (psel && penable && !pready) begin
            prdata_next = hit_ctrl ? ctrl_reg : hit_status ? status_word :
                          hit_err ? {23'h000000, errstat_reg} : 32'h0000_0000;
        end
        if (wr_take && hit_ctrl) begin
            ctrl_next = pwdata;
        end
        if (wr_take && hit_err) begin
            errstat_next = errstat_reg & ~pwdata[8:0];
        end
        // Set after clear so a same-cycle event survives
        errstat_next = errstat_next | err_event;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg    <= `PSAB_CTRL_RST;
            errstat_reg <= `PSAB_ERRSTAT_RST;
            prdata      <= 32'h0000_0000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            errstat_reg <= errstat_next;
            prdata      <= prdata_next;
            pready      <= pready_next;
            pslverr     <= pslverr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Parity error and system error pins
    psab_pkg::psab_pe_state_t pe_state_reg;
    psab_pkg::psab_pe_state_t pe_state_next;
    logic serr_any;
    logic serr_oe_next;

    always_comb begin
        pe_state_next = pe_state_reg;
        unique case (pe_state_reg)
            psab_pkg::pe_idle:    if (parity_err_detect) pe_state_next = psab_pkg::pe_assert;
            psab_pkg::pe_assert:  if (!parity_err_detect) pe_state_next = psab_pkg::pe_release;
            psab_pkg::pe_release: pe_state_next = parity_err_detect ? psab_pkg::pe_assert : psab_pkg::pe_idle;
        endcase
    end

    // Express-port errors only count in transparent mode
    assign serr_any = err_event.addr_parity || err_event.target_addr_parity
                   || err_event.master_abort_pw || err_event.target_abort_pw
                   || err_event.pw_discard || err_event.dw_discard
                   || err_event.dr_discard || err_event.dt_timeout
                   || (err_event.aer_error && ctrl_reg[`PSAB_CTRL_TRANSP]);
    assign serr_oe_next = ctrl_reg[`PSAB_CTRL_SERR_EN] && serr_any;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pe_state_reg     <= psab_pkg::pe_idle;
            parity_err_n_out <= 1'b1;
            parity_err_n_oe  <= 1'b0;
            system_err_n_out <= 1'b0;
            system_err_n_oe  <= 1'b0;
        end else begin
            pe_state_reg     <= pe_state_next;
            parity_err_n_out <= pe_state_next != psab_pkg::pe_assert;
            parity_err_n_oe  <= pe_state_next != psab_pkg::pe_idle;
            system_err_n_out <= 1'b0;
            system_err_n_oe  <= serr_oe_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Arbiter, grant pins and parking
    logic [4:0] arb_req;
    logic [3:0] grant_n_next;
    logic       bridge_gnt_next;
    logic       park_next;

    // Strapped request lines would look like constant requests, so mask them
    assign arb_req = {bridge_req, ~req_n_s[3] && !clock_run_n_mode_reg, ~req_n_s[2] && !clock_run_n_mode_reg,
                      ~req_n_s[1:0]};

    psab_arbiter #(.N(5), .IW(3)) u_arb (
        .mclk     (mclk),
        .rstn     (rstn),
        .enable   (strap_done_reg && !ext_mode),
        .bus_idle (bus_idle),
        .req      (arb_req),
        .gnt      (gnt_vec)
    );

    always_comb begin
        if (ext_mode) begin
            grant_n_next    = {ctrl_reg[`PSAB_CTRL_GPO_LSB +: 3], !bridge_req};
            bridge_gnt_next = !req_n_s[0];
        end else begin
            grant_n_next    = ~gnt_vec[3:0];
            bridge_gnt_next = gnt_vec[3:0] == 4'h0;
        end
        park_next = strap_done_reg && bus_idle && bridge_gnt_next;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            grant_n_out   <= 4'hF;
            grant_n_oe    <= 4'h0;
            bridge_gnt    <= 1'b0;
            park_drive_oe <= 1'b0;
        end else begin
            grant_n_out   <= grant_n_next;
            grant_n_oe    <= {4{strap_done_reg}};
            bridge_gnt    <= bridge_gnt_next && strap_done_reg;
            park_drive_oe <= park_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock outputs and interrupt pins
    logic [3:0] div_cnt_reg;
    logic [3:0] div_cnt_next;
    logic [3:0] div_sel;
    logic       tick;
    logic       tog_next;
    logic [3:0] pclk_next;
    logic [3:0] pclk_oe_next;

    // Speed pin picks the divider; the board owns its level
    assign div_sel = speed_s ? `PSAB_DIV_66 : `PSAB_DIV_33;
    assign tick    = div_cnt_reg >= div_sel - 4'h1;

    always_comb begin
        div_cnt_next = tick ? 4'h0 : div_cnt_reg + 4'h1;
        tog_next     = tick ? !pci_clock_out_out[1] : pci_clock_out_out[1];
        pclk_next    = {4{tog_next}};
        pclk_oe_next = 4'hF;
        if (ctrl_reg[`PSAB_CTRL_FEEDBACK]) begin
            pclk_oe_next[0] = 1'b0;
        end
        if (clock_run_n_mode_reg) begin
            pclk_next[3]    = 1'b0;
            pclk_oe_next[3] = ctrl_reg[`PSAB_CTRL_CLOCK_RUN_N];
            pclk_next[2]    = !ctrl_reg[`PSAB_CTRL_CLOCK_REQUEST_N];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div_cnt_reg       <= 4'h0;
            pci_clock_out_out <= 4'h0;
            pci_clock_out_oe  <= 4'h0;
            irq_out           <= 4'h0;
            irq_oe            <= 4'h0;
        end else begin
            div_cnt_reg       <= div_cnt_next;
            pci_clock_out_out <= pclk_next;
            pci_clock_out_oe  <= pclk_oe_next;
            irq_out           <= 4'h0;
            // Held by the control bits until the driver clears them
            irq_oe            <= reverse_reg ? ctrl_reg[`PSAB_CTRL_IRQ_LSB +: 4] : 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    a_perr_assert: assert property (@(posedge mclk) disable iff (!rstn)
        parity_err_detect |=> !parity_err_n_out && parity_err_n_oe)
        else $error("parity error not asserted after detect");
    a_perr_release: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(parity_err_n_oe) |-> $past(parity_err_n_out) && !$past(parity_err_n_out, 2))
        else $error("parity error released without one high cycle");
    a_serr_gate: assert property (@(posedge mclk) disable iff (!rstn)
        system_err_n_oe |-> $past(ctrl_reg[`PSAB_CTRL_SERR_EN]) && $past(serr_any))
        else $error("system error driven without enable and cause");
    a_serr_cause: assert property (@(posedge mclk) disable iff (!rstn)
        ctrl_reg[`PSAB_CTRL_SERR_EN] && (err_event.addr_parity || err_event.master_abort_pw
        || err_event.pw_discard || err_event.dt_timeout) |=> system_err_n_oe)
        else $error("system error missed");
    a_serr_aer: assert property (@(posedge mclk) disable iff (!rstn)
        (err_event == 9'h100) && !ctrl_reg[`PSAB_CTRL_TRANSP] |=> !system_err_n_oe)
        else $error("express error reported outside transparent mode");
    a_ext_request: assert property (@(posedge mclk) disable iff (!rstn)
        ext_mode ##1 ext_mode |-> grant_n_out[0] == !$past(bridge_req))
        else $error("bridge request not on grant 0");
    a_park_drive: assert property (@(posedge mclk) disable iff (!rstn)
        park_drive_oe |-> $past(bus_idle) && ($past(ext_mode) || grant_n_out == 4'hF))
        else $error("parking drive with bus busy or granted");
    a_reset_float: assert property (@(posedge mclk)
        !rstn |-> (grant_n_oe == 4'h0) && (pci_clock_out_oe == 4'h0) && !parity_err_n_oe
        && !system_err_n_oe && (irq_oe == 4'h0))
        else $error("output driven during reset");
    a_irq_dir: assert property (@(posedge mclk) disable iff (!rstn)
        !reverse_reg ##1 !reverse_reg |-> irq_oe == 4'h0)
        else $error("interrupt driven in forward mode");
    a_clk_feedback: assert property (@(posedge mclk) disable iff (!rstn)
        ctrl_reg[`PSAB_CTRL_FEEDBACK] |=> !pci_clock_out_oe[0])
        else $error("clock output 0 driven in feedback mode");

    c_perr_seq: cover property (@(posedge mclk) disable iff (!rstn)
        parity_err_detect ##1 !parity_err_detect ##1 parity_err_n_out ##1 !parity_err_n_oe);
    c_serr: cover property (@(posedge mclk) disable iff (!rstn) $rose(system_err_n_oe));
    c_grant: cover property (@(posedge mclk) disable iff (!rstn) $fell(grant_n_out[2]) && !ext_mode);
    c_clock_run_n: cover property (@(posedge mclk) disable iff (!rstn) strap_done_reg && clock_run_n_mode_reg);
endmodule : psab_top
`default_nettype wire

// file: pkg/psab_params.svh
// Constants of the PCI-side arbiter and sideband block: offsets, fields, resets, counts.
// Assumes inclusion by bare name from the top-level design module psab_top.
//
// What this block does
// - Pulse parity error low on data parity fault
// - Drive parity error high one cycle before release
// - System error pulled low only when enabled
// - Address parity and posted write aborts cause system error
// - Discards and delayed master timeout cause system error
// - Express port errors count in transparent mode
// - Arbiter grants one master, four grant outputs
// - Parked idle bus drives data, command, parity
// - External arbiter: request0 is grant, others inputs
// - External arbiter: grant0 is request, others outputs
// - Requests 2,3 low: clock run and request
// - Four clock outputs derived from clock input
// - Feedback mode turns clock output0 into input
// - Reset floats every PCI output asynchronously
// - Forward mode: interrupt pins are asynchronous inputs
// - Reverse mode: interrupt pins drive open drain
// - Interrupt stays asserted until driver clears it
// - Direction strap low forward, high reverse
`ifndef PSAB_PARAMS_SVH
`define PSAB_PARAMS_SVH

`define PSAB_OFF_CTRL        12'h000
`define PSAB_OFF_STATUS      12'h004
`define PSAB_OFF_ERRSTAT     12'h008

`define PSAB_CTRL_SERR_EN    0
`define PSAB_CTRL_TRANSP     1
`define PSAB_CTRL_EXT_ARB    2
`define PSAB_CTRL_FEEDBACK   3
`define PSAB_CTRL_GPO_LSB    4
`define PSAB_CTRL_IRQ_LSB    8
`define PSAB_CTRL_CLOCK_RUN_N     12
`define PSAB_CTRL_CLOCK_REQUEST_N     13
`define PSAB_CTRL_RST        32'h0000_0000

`define PSAB_ST_REVERSE      0
`define PSAB_ST_CLOCK_RUN_N_MODE  1
`define PSAB_ST_SPEED66      2
`define PSAB_ST_PARK         3
`define PSAB_ST_GPI_LSB      4
`define PSAB_ST_IRQ_LSB      8
`define PSAB_ST_GNT_LSB      12
`define PSAB_ST_FB_CLK       17
`define PSAB_ST_SERR_LINE    18

`define PSAB_ERRSTAT_RST     9'h000
`define PSAB_SYNC_RST        12'hFFF
`define PSAB_STRAP_WAIT      3'h4
`define PSAB_DIV_66          4'h1
`define PSAB_DIV_33          4'h2

`endif

// file: pkg/psab_pkg.sv
// Types shared by the PCI-side arbiter and sideband modules.
// Assumes the constants header is on the include path.
package psab_pkg;

    typedef struct packed {
        logic irq_d_n;
        logic irq_c_n;
        logic irq_b_n;
        logic irq_a_n;
    } psab_irq_t;

    typedef struct packed {
        logic aer_error;
        logic dt_timeout;
        logic dr_discard;
        logic dw_discard;
        logic pw_discard;
        logic target_abort_pw;
        logic master_abort_pw;
        logic target_addr_parity;
        logic addr_parity;
    } psab_err_t;

    typedef enum logic [1:0] {pe_idle, pe_assert, pe_release} psab_pe_state_t;

endpackage : psab_pkg

// file: src/psab_sync.sv
// Three-flop pin synchroniser with agreement filter.
// Assumes asynchronous inputs and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module psab_sync #(
    parameter int              W       = 12,
    parameter logic [W-1:0]    RST_VAL = '1
) (
    input  wire logic          mclk,
    input  wire logic          rstn,
    input  wire logic [W-1:0]  pin_in,
    output logic      [W-1:0]  level_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] level_next;

    // Only the second and third stages are compared; the first is left alone
    always_comb begin
        level_next = level_out;
        for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                level_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s1_reg    <= RST_VAL;
            s2_reg    <= RST_VAL;
            s3_reg    <= RST_VAL;
            level_out <= RST_VAL;
        end else begin
            s1_reg    <= pin_in;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_out <= level_next;
        end
    end
endmodule : psab_sync
`default_nettype wire

// file: src/psab_arbiter.sv
// Round-robin PCI bus arbiter, one-hot grant, moves only on an idle bus.
// Assumes synchronised active-high requests from the same clock.
`timescale 1ns/1ps
`default_nettype none
module psab_arbiter #(
    parameter int N  = 5,
    parameter int IW = 3
) (
    input  wire logic          mclk,
    input  wire logic          rstn,
    input  wire logic          enable,
    input  wire logic          bus_idle,
    input  wire logic [N-1:0]  req,
    output logic      [N-1:0]  gnt
);
    logic [N-1:0]  gnt_next;
    logic [IW-1:0] last_reg;
    logic [IW-1:0] last_next;
    logic [N-1:0]  pick;

    function automatic logic [IW-1:0] rr_index(input logic [N-1:0] r, input logic [IW-1:0] last);
        logic [IW-1:0] idx;
        logic          found;
        int            k;
        idx   = last;
        found = 1'b0;
        for (int i = 1; i <= N; i++) begin
            k = (int'(last) + i) % N;
            if (r[k] && !found) begin
                idx   = IW'(k);
                found = 1'b1;
            end
        end
        return idx;
    endfunction : rr_index

    always_comb begin
        pick      = '0;
        gnt_next  = gnt;
        last_next = last_reg;
        pick[rr_index(req, last_reg)] = |req;
        if (!enable) begin
            gnt_next = '0;
        end else if (|gnt) begin
            // A dropped request frees the bus; masters hold it high two clocks
            if (!(|(gnt & req))) begin
                gnt_next = '0;
            end
        end else if (bus_idle && (|req)) begin
            gnt_next  = pick;
            last_next = rr_index(req, last_reg);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gnt      <= '0;
            last_reg <= '0;
        end else begin
            gnt      <= gnt_next;
            last_reg <= last_next;
        end
    end

    a_gnt_onehot: assert property (@(posedge mclk) disable iff (!rstn) $onehot0(gnt))
        else $error("more than one grant");
    a_gnt_cause: assert property (@(posedge mclk) disable iff (!rstn)
        ($rose(gnt[0]) || $rose(gnt[1]) || $rose(gnt[2]) || $rose(gnt[3])) |-> $past(bus_idle && enable))
        else $error("grant moved outside idle bus");
endmodule : psab_arbiter
`default_nettype wire

// file: bench/psab_master_model.sv
// Behavioural PCI masters driving the four request pins.
// Assumes want[] from the bench; pins idle high via pull-up.
`timescale 1ns/1ps
`default_nettype none
module psab_master_model (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic [3:0] want,
    output logic      [3:0] req_n
);
    logic [1:0] idle [4];
    always_ff @(posedge mclk or negedge rstn) begin
        for (int i = 0; i < 4; i++) begin
            if (!rstn) begin
                req_n[i] <= 1'b1;
                idle[i]  <= 2'h0;
            end else if (want[i] && (!req_n[i] || idle[i] >= 2'h2)) begin
                req_n[i] <= 1'b0;
                idle[i]  <= 2'h0;
            end else begin
                req_n[i] <= 1'b1;
                idle[i]  <= (idle[i] == 2'h3) ? 2'h3 : idle[i] + 2'h1;
            end
        end
    end
endmodule : psab_master_model
`default_nettype wire

// file: bench/pci_side_arbiter_sideband_test.sv
// Self-checking bench for the PCI-side sideband block.
// Assumes the package and the master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pci_side_arbiter_sideband_test;
    logic mclk, rstn, psel, penable, pwrite, pready, pslverr, pdet, pe_o, pe_oe, se_oe, spd, breq, bgnt, pk, p;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  want, req_n, gnt_n, gnt_oe, pco, pco_oe;
    logic [8:0]  ev, ee;
    logic        e;
    int          num_errors, comparisons, n, b;
    psab_master_model u_psab_master_model (.mclk(mclk), .rstn(rstn), .want(want), .req_n(req_n));
    psab_top u_psab_top (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bridge_direction_strap(1'b0), .speed_66_enable(spd), .req_n_in(req_n), .grant_n_out(gnt_n),
        .grant_n_oe(gnt_oe), .pci_clock_out_in(4'h0), .pci_clock_out_out(pco), .pci_clock_out_oe(pco_oe),
        .parity_err_detect(pdet), .parity_err_n_out(pe_o), .parity_err_n_oe(pe_oe),
        .system_err_n_in(1'b1), .system_err_n_out(), .system_err_n_oe(se_oe), .irq_in(4'hF),
        .irq_out(), .irq_oe(), .err_event(ev), .bus_idle(1'b1), .bridge_req(breq),
        .park_drive_oe(pk), .bridge_gnt(bgnt));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task give_verdict;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do @(posedge mclk); while (pready !== 1'b1 && ++n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        // One idle edge so a following call never re-raises psel in the same step
        @(posedge mclk);
        if (n >= 20) begin num_errors++; give_verdict(); end
    endtask : apb
    task wait_gnt(input logic [3:0] exp);
        n = 0;
        while (gnt_n !== exp && ++n < 40) @(posedge mclk);
        chk(gnt_n, exp);
    endtask : wait_gnt
    initial begin
        void'($urandom(32'h7C0F));
        rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        pdet = 1'b0; ev = 9'h000; ee = 9'h000; breq = 1'b0; want = 4'h0; spd = 1'($urandom);
        repeat (12) @(posedge mclk);
        chk({gnt_oe, pco_oe, pe_oe, se_oe}, 10'h000);
        rstn <= 1'b1;
        repeat (8) @(posedge mclk);
        apb(1'b0, 12'h004, 32'h0);
        chk(r[3:0], {1'b1, spd, 2'b00});
        b = 0;
        for (int i = 0; i < 16; i++) begin
            p = pco[1];
            @(posedge mclk);
            b += int'(pco[1] != p);
        end
        // Divider 1 toggles on every edge, divider 2 on every other
        chk(b, spd ? 32'h10 : 32'h8);
        chk(pco_oe, 4'hF);
        apb(1'b0, 12'h00C, 32'h0);
        chk(e, 1'b1);
        chk(r, 32'h0000_0000);
        for (int k = 0; k < 24; k++) begin
            b = $urandom % 9;
            apb(1'b1, 12'h000, 32'(k % 4));
            ev <= 9'h001 << b;
            ee = ee | (9'h001 << b);
            @(posedge mclk);
            ev <= 9'h000;
            #1 chk(se_oe, (k % 2) && (b < 8 || k % 4 == 3));
            @(posedge mclk);
        end
        // Error flags latch every event and clear on a written one
        apb(1'b0, 12'h008, 32'h0);
        chk(r, {23'h000000, ee});
        apb(1'b1, 12'h008, 32'h0000_01FF);
        apb(1'b0, 12'h008, 32'h0);
        chk(r, 32'h0000_0000);
        pdet <= 1'b1;
        @(posedge mclk);
        pdet <= 1'b0;
        #1 chk({pe_o, pe_oe}, 2'b01);
        @(posedge mclk);
        #1 chk({pe_o, pe_oe}, 2'b11);
        @(posedge mclk);
        #1 chk(pe_oe, 1'b0);
        for (int m = 0; m < 4; m++) begin
            want <= 4'h1 << m;
            wait_gnt(~(4'h1 << m));
            want <= 4'h0;
            wait_gnt(4'hF);
        end
        // Contention: a fixed priority would return to master 0 in the third step
        want <= 4'hF;
        wait_gnt(4'hE);
        want <= 4'hE;
        wait_gnt(4'hD);
        want <= 4'hD;
        wait_gnt(4'hB);
        want <= 4'h0;
        wait_gnt(4'hF);
        breq <= 1'b1;
        apb(1'b1, 12'h000, 32'h0000_0054);
        want <= 4'h5;
        repeat (10) @(posedge mclk);
        chk(gnt_n, 4'hA);
        chk({bgnt, pk}, 2'b11);
        apb(1'b0, 12'h004, 32'h0);
        chk(r[6:4], 3'h5);
        give_verdict();
    end
    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end
endmodule : pci_side_arbiter_sideband_test
`default_nettype wire
